/* esr_pkg.sv */
// Package: constants and types for the external stop request selector
package esr_pkg;
  // ===========================================================
  // Register map (byte addresses)
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_INT_ST = 8'h08;
  localparam logic [7:0] ADDR_INT_MK = 8'h0C;
  localparam logic [7:0] ADDR_TOL    = 8'h10;
  // ===========================================================
  // Field positions in the control word
  localparam int CTRL_EN_SAFE_STANDSTILL = 0;
  localparam int CTRL_EN_RETRACT         = 4;
  localparam int CTRL_EN_EXT_STOPS       = 6;
  localparam int CTRL_STOP_MODE_LSB      = 8;
  localparam int CTRL_PLC_MODE4          = 12;
  localparam int CTRL_XCMP_STARTED       = 13;
  localparam logic [2:0] STOP_MODE_RETRACT = 3'h4;
  // ===========================================================
  // Interrupt status bit positions
  localparam int IRQ_CHANGE   = 0;
  localparam int IRQ_ALARM    = 1;
  localparam int IRQ_MISMATCH = 2;
  localparam int IRQ_STOP     = 3;
  localparam int IRQ_W        = 4;
  // ===========================================================
  // Reset values and timing
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [15:0] TOL_RST  = 16'h0064;
  localparam int CLK_HZ            = 25_000_000;
  localparam int MON_CYCLE_US      = 2;
  localparam int MON_DIV = CLK_HZ / 1_000_000 * MON_CYCLE_US;
  typedef enum logic [2:0] {
    ESR_NONE, ESR_STOP_A, ESR_STOP_C, ESR_STOP_D, ESR_STOP_E
  } esr_stop_t;
endpackage

/* esr_sync.sv */
// Two flip-flop synchroniser for a vector of pin inputs
`timescale 1ns/1ps
`default_nettype none
module esr_sync #(
  parameter int W = 4
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;
  // Deselected (high) at reset so a spurious stop cannot appear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '1;
      q      <= '1;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule
`default_nettype wire

/* esr_tick.sv */
// Divider producing the monitoring cycle enable pulse
`timescale 1ns/1ps
`default_nettype none
module esr_tick #(
  parameter int DIV = 50
) (
  input  wire logic pclk,
  input  wire logic presetn,
  output logic      tick
);
  logic [15:0] cnt_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 16'h0000;
      tick  <= 1'b0;
    end else if (cnt_q == 16'(DIV - 1)) begin
      cnt_q <= 16'h0000;
      tick  <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
      tick  <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* esr_top.sv */
// External stop request selector with APB registers and interrupt
//
// How it works
// - Four external stops: A, C, D, E
// - Stop inputs active low, high deselects
// - Only highest priority stop executes: A>C>D>E
// - Works only with external-stops enable bit
// - Retract stop also needs its own enable
// - Stop A held until cross-comparison starts
// - Retract stop blocked without own enable
// - Stop mode 4: errors trigger retract stop
// - Alarm when mode 4 with safe standstill enabled but no retract enable
// - PLC stop mode compared with kernel setting
// - Any stop input change starts tolerance timer
// - Stop A reports pulses cancelled, stop-A active
// - Stop C asserts stop-C active
// - Stop D asserts stop-D active
// - External stops raise no alarm themselves
`timescale 1ns/1ps
`default_nettype none
module esr_top
  import esr_pkg::*;
#(
  parameter int MON_DIV_P = esr_pkg::MON_DIV
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [3:0]  safe_input_signal_n,
  input  wire logic        xcmp_error,
  output logic             pulses_cancelled,
  output logic             stop_a_active,
  output logic             stop_c_active,
  output logic             stop_d_active,
  output logic             stop_e_active,
  output logic             tol_running,
  output logic             alarm_no_retract,
  output logic             irq
);
  import esr_pkg::*;

  // ===========================================================
  // Input synchronisation and monitoring cycle
  logic [3:0] sin_s;
  logic [3:0] sin_prev_q;
  logic       tick;
  logic       xerr_s;
  logic [1:0] xerr_m_q;

  esr_sync #(.W(4)) esr_sync_i (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (safe_input_signal_n),
    .q       (sin_s)
  );
  esr_tick #(.DIV(MON_DIV_P)) esr_tick_i (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (tick)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xerr_m_q <= 2'b00;
    end else begin
      xerr_m_q <= {xerr_m_q[0], xcmp_error};
    end
  end
  assign xerr_s = xerr_m_q[1];

  // ===========================================================
  // Registers
  logic [31:0] ctrl_q;
  logic [15:0] tol_q;
  logic [IRQ_W-1:0] ist_q;
  logic [IRQ_W-1:0] imk_q;

  wire wr_en   = psel && penable && pwrite;
  wire en_ext  = ctrl_q[CTRL_EN_EXT_STOPS];
  wire en_ret  = ctrl_q[CTRL_EN_RETRACT];
  wire xcmp_go = ctrl_q[CTRL_XCMP_STARTED];
  wire [2:0] stop_mode = ctrl_q[CTRL_STOP_MODE_LSB +: 3];
  wire mode4   = (stop_mode == STOP_MODE_RETRACT);
  wire addr_ok = (paddr == ADDR_CTRL) || (paddr == ADDR_STATUS) ||
                 (paddr == ADDR_INT_ST) || (paddr == ADDR_INT_MK) ||
                 (paddr == ADDR_TOL);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RST;
      tol_q  <= TOL_RST;
      imk_q  <= '0;
    end else if (wr_en) begin
      if (paddr == ADDR_CTRL)   ctrl_q <= pwdata;
      if (paddr == ADDR_TOL)    tol_q  <= pwdata[15:0];
      if (paddr == ADDR_INT_MK) imk_q  <= pwdata[IRQ_W-1:0];
    end
  end

  // ===========================================================
  // Request qualification and priority
  wire [3:0] req = ~sin_s;
  // Until the cross-comparison runs, stop A stays forced for safety
  wire req_a = en_ext && (req[0] || !xcmp_go);
  wire req_c = en_ext && req[1];
  wire req_d = en_ext && (req[2] || (xerr_s && !mode4));
  wire req_e = en_ext && en_ret && (req[3] || (xerr_s && mode4));

  esr_stop_t sel;
  always_comb begin
    if (req_a)      sel = ESR_STOP_A;
    else if (req_c) sel = ESR_STOP_C;
    else if (req_d) sel = ESR_STOP_D;
    else if (req_e) sel = ESR_STOP_E;
    else            sel = ESR_NONE;
  end

  // ===========================================================
  // Feedback outputs, updated once per monitoring cycle
  esr_stop_t act_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_q            <= ESR_NONE;
      pulses_cancelled <= 1'b0;
      stop_a_active    <= 1'b0;
      stop_c_active    <= 1'b0;
      stop_d_active    <= 1'b0;
      stop_e_active    <= 1'b0;
    end else if (tick) begin
      act_q            <= sel;
      pulses_cancelled <= (sel == ESR_STOP_A);
      stop_a_active    <= (sel == ESR_STOP_A);
      stop_c_active    <= (sel == ESR_STOP_C);
      stop_d_active    <= (sel == ESR_STOP_D);
      stop_e_active    <= (sel == ESR_STOP_E);
    end
  end

  // ===========================================================
  // Changeover tolerance timer
  logic [15:0] tol_cnt_q;
  wire in_change = (sin_s != sin_prev_q);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sin_prev_q  <= 4'hF;
      tol_cnt_q   <= 16'h0000;
      tol_running <= 1'b0;
    end else begin
      sin_prev_q <= sin_s;
      if (in_change) begin
        tol_cnt_q   <= tol_q;
        tol_running <= (tol_q != 16'h0000);
      end else if (tick && tol_cnt_q != 16'h0000) begin
        tol_cnt_q   <= tol_cnt_q - 16'h0001;
        tol_running <= (tol_cnt_q != 16'h0001);
      end
    end
  end

  // ===========================================================
  // Configuration alarm and channel cross-check
  wire cfg_alarm = mode4 && ctrl_q[CTRL_EN_SAFE_STANDSTILL] && !en_ret;
  wire mismatch  = xcmp_go && (ctrl_q[CTRL_PLC_MODE4] != mode4);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) alarm_no_retract <= 1'b0;
    else          alarm_no_retract <= cfg_alarm;
  end

  // ===========================================================
  // Interrupt status: set wins over write-one-to-clear
  // A stop selection is an event only, never an alarm
  logic [IRQ_W-1:0] ev;
  assign ev[IRQ_CHANGE]   = in_change;
  assign ev[IRQ_ALARM]    = cfg_alarm;
  assign ev[IRQ_MISMATCH] = mismatch;
  assign ev[IRQ_STOP]     = tick && (sel != act_q);
  wire [IRQ_W-1:0] w1c = (wr_en && paddr == ADDR_INT_ST) ?
                         pwdata[IRQ_W-1:0] : '0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ist_q <= '0;
      irq   <= 1'b0;
    end else begin
      ist_q <= (ist_q & ~w1c) | ev;
      irq   <= |(((ist_q & ~w1c) | ev) & imk_q);
    end
  end

  // ===========================================================
  // APB read path, zero wait states
  wire [31:0] status_w = {16'h0000, tol_cnt_q[7:0], 1'b0, act_q,
                          tol_running, mismatch, cfg_alarm, xcmp_go};
  logic [31:0] rdata_d;
  always_comb begin
    case (paddr)
      ADDR_CTRL:   rdata_d = ctrl_q;
      ADDR_STATUS: rdata_d = status_w;
      ADDR_INT_ST: rdata_d = {28'h0000000, ist_q};
      ADDR_INT_MK: rdata_d = {28'h0000000, imk_q};
      ADDR_TOL:    rdata_d = {16'h0000, tol_q};
      default:     rdata_d = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      if (psel && !penable && !pwrite) prdata <= rdata_d;
    end
  end

  // ===========================================================
  // Assertions
  property p_prio_a;
    @(posedge pclk) disable iff (!presetn)
      tick && req_a |=> stop_a_active && !stop_c_active && !stop_d_active;
  endproperty
  a_prio_a: assert property (p_prio_a) else $error("stop A not exclusive");
  property p_disabled;
    @(posedge pclk) disable iff (!presetn)
      tick && !en_ext |=> !stop_a_active && !stop_c_active
                          && !stop_d_active && !stop_e_active;
  endproperty
  a_disabled: assert property (p_disabled) else $error("stop while off");
  property p_ret_en;
    @(posedge pclk) disable iff (!presetn)
      tick && !en_ret |=> !stop_e_active;
  endproperty
  a_ret_en: assert property (p_ret_en) else $error("E without enable");
  property p_xcmp;
    @(posedge pclk) disable iff (!presetn)
      tick && en_ext && !xcmp_go |=> stop_a_active;
  endproperty
  a_xcmp: assert property (p_xcmp) else $error("A not held");
  property p_mode4;
    @(posedge pclk) disable iff (!presetn)
      tick && en_ext && mode4 && xerr_s && !(|req[2:0]) && xcmp_go
        |=> !stop_d_active;
  endproperty
  a_mode4: assert property (p_mode4) else $error("D in mode 4");
  property p_alarm;
    @(posedge pclk) disable iff (!presetn)
      cfg_alarm |=> alarm_no_retract;
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm missing");
  property p_tol;
    @(posedge pclk) disable iff (!presetn)
      in_change && tol_q != 16'h0000 |=> tol_running;
  endproperty
  a_tol: assert property (p_tol) else $error("timer not started");
  property p_fb_a;
    @(posedge pclk) disable iff (!presetn)
      stop_a_active |-> pulses_cancelled;
  endproperty
  a_fb_a: assert property (p_fb_a) else $error("A feedback split");
  property p_clear;
    @(posedge pclk) disable iff (!presetn)
      tick && sel == ESR_NONE |=> !stop_c_active && !stop_d_active;
  endproperty
  a_clear: assert property (p_clear) else $error("feedback stuck");
  property p_prio_c;
    @(posedge pclk) disable iff (!presetn)
      tick && req_c && !req_a |=> stop_c_active && !stop_a_active
                                  && !stop_d_active && !stop_e_active;
  endproperty
  a_prio_c: assert property (p_prio_c) else $error("stop C lost");
  property p_prio_d;
    @(posedge pclk) disable iff (!presetn)
      tick && req_d && !req_a && !req_c |=> stop_d_active && !stop_e_active;
  endproperty
  a_prio_d: assert property (p_prio_d) else $error("stop D lost");
  property p_stop_e;
    @(posedge pclk) disable iff (!presetn)
      tick && req_e && !req_a && !req_c && !req_d |=> stop_e_active;
  endproperty
  a_stop_e: assert property (p_stop_e) else $error("stop E lost");
  // Feedback may only move on a monitoring tick
  property p_hold;
    @(posedge pclk) disable iff (!presetn)
      !tick |=> $stable(stop_a_active) && $stable(stop_c_active) &&
                $stable(stop_d_active) && $stable(stop_e_active);
  endproperty
  a_hold: assert property (p_hold) else $error("feedback off tick");
  property p_alarm_off;
    @(posedge pclk) disable iff (!presetn)
      !cfg_alarm |=> !alarm_no_retract;
  endproperty
  a_alarm_off: assert property (p_alarm_off) else $error("alarm stuck");
  c_stop_a: cover property (@(posedge pclk) stop_a_active);
  c_alarm:  cover property (@(posedge pclk) alarm_no_retract);
  c_stop_c: cover property (@(posedge pclk) stop_c_active);
  c_stop_e: cover property (@(posedge pclk) stop_e_active);
  c_irq:    cover property (@(posedge pclk) irq);
endmodule
`default_nettype wire

/* esr_sensor.sv */
// Behavioural model of the safety sensors driving the stop inputs
`timescale 1ns/1ps
`default_nettype none
module esr_sensor (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       slow,
  input  wire logic [3:0] req,
  output logic      [3:0] sig_n
);
  logic [3:0] dly_q;
  // A request pulls its line low; an unused line sits at 1 for good
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dly_q <= 4'hF;
      sig_n <= 4'hF;
    end else begin
      dly_q <= ~req;
      sig_n <= slow ? dly_q : ~req;
    end
  end
endmodule
`default_nettype wire

/* esr_top_tb.sv */
// Self-checking bench for the external stop request selector
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
  num_errors++; $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module esr_top_tb;
  import esr_pkg::*;
  localparam int DIV = 4;
  logic        pclk, presetn, psel, penable, pwrite, xcmp_error;
  logic        pready, pslverr, pulses_cancelled, tol_running;
  logic        stop_a_active, stop_c_active, stop_d_active;
  logic        stop_e_active, alarm_no_retract, irq, slow;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  sin_n, sreq;
  logic [4:0]  fb;
  int          num_errors, cmp_count, cyc;
  logic [3:0]  rq [8] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'hF, 4'h6, 4'hC, 4'h3};
  logic [4:0]  ex [8] = '{5'h18, 5'h04, 5'h02, 5'h01, 5'h18, 5'h04,
                         5'h02, 5'h18};
  assign fb = {pulses_cancelled, stop_a_active, stop_c_active,
               stop_d_active, stop_e_active};
  esr_top #(.MON_DIV_P(DIV)) esr_top_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .safe_input_signal_n(sin_n), .xcmp_error(xcmp_error),
    .pulses_cancelled(pulses_cancelled), .stop_a_active(stop_a_active),
    .stop_c_active(stop_c_active), .stop_d_active(stop_d_active),
    .stop_e_active(stop_e_active), .tol_running(tol_running),
    .alarm_no_retract(alarm_no_retract), .irq(irq));
  // Bit 0 is stop A, then C, D and E, one request line each
  esr_sensor esr_sensor_i (.pclk(pclk), .presetn(presetn), .slow(slow),
    .req(sreq), .sig_n(sin_n));
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // ==========================================================
  // Bus access and checks
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic err);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    // One idle edge so the next setup never overwrites this release
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic e;
    apb(1'b1, a, d, e);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic er;
    apb(1'b0, a, 32'h0, er);
    `CHK("read", e, rd)
  endtask
  // Slowest path: sensor, sync, one tick, register
  task automatic stp(input logic [3:0] r, input logic [4:0] e);
    sreq <= r;
    repeat (3 * DIV + 8) @(posedge pclk);
    `CHK("feedback", e, fb)
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 6000) begin
      num_errors++;
      results();
    end
  end
  // ==========================================================
  // Test sequence
  initial begin
    logic e;
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; xcmp_error = 1'b0; sreq = 4'h0;
    slow = 1'b0; num_errors = 0; cmp_count = 0; cyc = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rchk(ADDR_CTRL, CTRL_RST);
    rchk(ADDR_TOL, {16'h0, TOL_RST});
    apb(1'b0, 8'h40, 32'h0, e);
    `CHK("unmapped err", 1'b1, e)
    $display("test reset done");
    wr(ADDR_CTRL, 32'h0000_0041);
    stp(4'h0, 5'h18);
    wr(ADDR_CTRL, 32'h0000_2001);
    stp(4'h1, 5'h00);
    wr(ADDR_CTRL, 32'h0000_2041);
    stp(4'h8, 5'h00);
    stp(4'h0, 5'h00);
    wr(ADDR_INT_ST, 32'h0000_000F);
    wr(ADDR_INT_MK, 32'h0000_0000);
    wr(ADDR_CTRL, 32'h0000_2051);
    for (int i = 0; i < 8; i++) begin
      slow <= i[0];
      stp(rq[i], ex[i]);
    end
    `CHK("tol", 1'b1, tol_running)
    `CHK("irq masked", 1'b0, irq)
    apb(1'b0, ADDR_INT_ST, 32'h0, e);
    `CHK("change flag", 1'b1, rd[IRQ_CHANGE])
    stp(4'h0, 5'h00);
    wr(ADDR_INT_MK, 32'h0000_0001);
    @(posedge pclk);
    `CHK("irq", 1'b1, irq)
    wr(ADDR_INT_ST, 32'h0000_000F);
    @(posedge pclk);
    `CHK("irq clr", 1'b0, irq)
    $display("test priority done");
    wr(ADDR_CTRL, 32'h0000_3441);
    stp(4'h0, 5'h00);
    `CHK("alarm", 1'b1, alarm_no_retract)
    wr(ADDR_CTRL, 32'h0000_3451);
    xcmp_error <= 1'b1;
    stp(4'h0, 5'h01);
    `CHK("alarm off", 1'b0, alarm_no_retract)
    wr(ADDR_CTRL, 32'h0000_2051);
    stp(4'h0, 5'h02);
    xcmp_error <= 1'b0;
    wr(ADDR_CTRL, 32'h0000_2451);
    stp(4'h0, 5'h00);
    apb(1'b0, ADDR_STATUS, 32'h0, e);
    `CHK("mismatch", 1'b1, rd[2])
    $display("test mode done");
    results();
  end
endmodule
`default_nettype wire
